// *** sarpi_device.sv ***
module sarpi_device
   import sarpi_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC
)
(
   // Clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_arst_n,
   // Link
   sarpi_if.dev                   io,
   // Converter core
   input  wire logic [DATA_W-1:0] i_sample_code,
   output logic      [OFFS_W-1:0] o_offset,
   output logic                   o_result_invalid
);

   if (CONV_CYCLES < 1 || CONV_CYCLES > 255)
      $error("CONV_CYCLES must lie in 1..255");

   typedef struct packed {
      logic              conversion_start_n_q;
      logic              busy;
      logic [7:0]        cnt;
      logic [DATA_W-1:0] sample;
      logic [DATA_W-1:0] out_reg;
      logic [DATA_W-1:0] pending;
      logic              have_pending;
      logic              out_valid;
      logic [OFFS_W-1:0] offset;
   } sarpi_dev_s;

   sarpi_dev_s r;
   sarpi_dev_s next_r;
   logic       fall;
   logic [DATA_W-1:0] corrected;

   // ------------------------------------------------------------
   // Conversion and output register
   // ------------------------------------------------------------
   always_comb
   begin
      next_r     = r;
      fall       = r.conversion_start_n_q && !io.conversion_start_n;
      corrected  = r.sample + {{(DATA_W-OFFS_W){r.offset[OFFS_W-1]}}, r.offset};
      next_r.conversion_start_n_q = io.conversion_start_n;
      if (!r.busy)
      begin
         if (r.cnt == 8'h00)
         begin
            next_r.busy = 1'b1;
            if (io.mode == MODE_DEFERRED)
            begin
               next_r.pending      = corrected;
               next_r.have_pending = 1'b1;
            end
            else
            begin
               next_r.out_reg   = corrected;
               next_r.out_valid = 1'b1;
            end
         end
         else
            next_r.cnt = r.cnt - 8'h01;
      end
      else if (fall)
      begin
         // Edges during a conversion are ignored: the SAR cannot restart mid-cycle
         next_r.busy   = 1'b0;
         next_r.cnt    = 8'(CONV_CYCLES - 1);
         next_r.sample = i_sample_code;
         if (io.mode == MODE_DEFERRED)
         begin
            next_r.out_reg   = r.pending;
            next_r.out_valid = r.have_pending;
         end
      end
      else if (!io.cs_n && !io.wr_n)
         next_r.offset = io.result_bus[OFFS_W-1:0];
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         r        <= '0;
         r.conversion_start_n_q <= 1'b1;
         r.busy   <= 1'b1;
         r.offset <= OFFSET_RESET;
      end
      else
         r <= next_r;
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   assign io.busy          = r.busy;
   assign io.dev_d         = r.out_reg;
   assign io.dev_oe        = !io.cs_n && !io.rd_n;
   assign o_offset         = r.offset;
   assign o_result_invalid = !r.out_valid;

endmodule

// *** sarpi_host.sv ***
// The address-and-strobe port and the register addresses were chosen for this implementation.
module sarpi_host
   import sarpi_pkg::*;
(
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   // Link
   sarpi_if.host            io,
   // Register port
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   output logic             o_irq
);

   typedef struct packed {
      sarpi_state_e      st;
      logic [7:0]        cnt;
      logic [1:0]        mode;
      logic [OFFS_W-1:0] offset;
      logic              start_req;
      logic              offset_req;
      logic [DATA_W-1:0] result;
      logic              stale;
      logic              seen;
      logic [STAT_W-1:0] status;
      logic [STAT_W-1:0] mask;
      logic [15:0]       rdata;
      logic              conversion_start_n_n;
      logic              cs_n;
      logic              rd_n;
      logic              wr_n;
      logic              drive;
   } sarpi_host_s;

   sarpi_host_s r;
   sarpi_host_s next_r;
   logic [STAT_W-1:0] set;
   logic [STAT_W-1:0] clr;
   int                wval;

   // Load a countdown for a phase of given length
   function automatic logic [7:0] phase_len(input int cyc);
      return 8'(cyc - 1);
   endfunction

   always_comb
   begin
      next_r = r;
      set    = '0;
      clr    = '0;
      wval   = int'($signed(i_wdata[OFFS_W-1:0]));
      // ------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------
      if (i_wr)
      begin
         unique case (i_addr)
            REG_CTRL:
               if (i_wdata[1:0] == MODE_IMMEDIATE || i_wdata[1:0] == MODE_DEFERRED)
                  next_r.mode = i_wdata[1:0];
            REG_CMD:
            begin
               if (i_wdata[CMD_START_BIT])
                  next_r.start_req = 1'b1;
               if (i_wdata[CMD_OFFSET_BIT])
                  next_r.offset_req = 1'b1;
            end
            REG_OFFSET:
               if (wval >= OFFSET_MIN && wval <= OFFSET_MAX)
                  next_r.offset = i_wdata[OFFS_W-1:0];
               else
                  set[STAT_RANGE_BIT] = 1'b1;
            REG_STATUS:
               clr = i_wdata[STAT_W-1:0];
            REG_MASK:
               next_r.mask = i_wdata[STAT_W-1:0];
            default:
               ;
         endcase
      end
      // ------------------------------------------------------------
      // Register reads, answered one cycle later
      // ------------------------------------------------------------
      next_r.rdata = 16'h0000;
      if (i_rd)
      begin
         unique case (i_addr)
            REG_CTRL:   next_r.rdata = {14'h0000, r.mode};
            REG_CMD:    next_r.rdata = {13'h0000, r.st != SARPI_IDLE, r.offset_req, r.start_req};
            REG_OFFSET: next_r.rdata = {4'h0, r.offset};
            REG_RESULT: next_r.rdata = {r.stale, r.result};
            REG_STATUS: next_r.rdata = {13'h0000, r.status};
            REG_MASK:   next_r.rdata = {13'h0000, r.mask};
            default:    next_r.rdata = 16'h0000;
         endcase
      end
      // ------------------------------------------------------------
      // Link sequencer
      // ------------------------------------------------------------
      if (r.cnt != 8'h00)
         next_r.cnt = r.cnt - 8'h01;
      unique case (r.st)
         SARPI_IDLE:
            if (r.offset_req)
            begin
               // Offset is only sent while idle, hence between conversions;
               // a request written in this very cycle is kept, not lost
               next_r.offset_req = i_wr && (i_addr == REG_CMD) && i_wdata[CMD_OFFSET_BIT];
               next_r.st   = SARPI_WRITE;
               next_r.cnt  = phase_len(WR_CYC);
               next_r.cs_n = 1'b0;
               next_r.wr_n = 1'b0;
               next_r.drive = 1'b1;
            end
            else if (r.start_req)
            begin
               next_r.start_req = i_wr && (i_addr == REG_CMD) && i_wdata[CMD_START_BIT];
               // A full start, convert, read and quiet round lasts well over 400 ns,
               // so immediate readout never outruns its rate limit
               next_r.st       = SARPI_CONVERSION_START_N;
               next_r.cnt      = phase_len(CONVERSION_START_N_CYC);
               next_r.conversion_start_n_n = 1'b0;
            end
         SARPI_WRITE:
            if (r.cnt == 8'h00)
            begin
               next_r.cs_n  = 1'b1;
               next_r.wr_n  = 1'b1;
               next_r.drive = 1'b0;
               next_r.st    = SARPI_QUIET;
               next_r.cnt   = phase_len(QUIET_CYC);
            end
         SARPI_CONVERSION_START_N:
            if (r.cnt == 8'h00)
            begin
               next_r.conversion_start_n_n = 1'b1;
               next_r.st       = SARPI_WAIT_LOW;
            end
         SARPI_WAIT_LOW:
            if (!io.busy)
               next_r.st = SARPI_WAIT_HIGH;
         SARPI_WAIT_HIGH:
            if (io.busy)
            begin
               next_r.st   = SARPI_READ;
               next_r.cnt  = phase_len(RD_CYC);
               next_r.cs_n = 1'b0;
               // Selects are pulsed per read: the round is never fast enough to need them tied low
               next_r.rd_n = 1'b0;
            end
         SARPI_READ:
            if (r.cnt == 8'h00)
            begin
               next_r.result = io.result_bus;
               next_r.stale  = (r.mode == MODE_DEFERRED) && !r.seen;
               next_r.seen   = 1'b1;
               set[STAT_DONE_BIT] = 1'b1;
               set[STAT_OVR_BIT]  = io.result_bus[OVR_BIT];
               next_r.cs_n = 1'b1;
               next_r.rd_n = 1'b1;
               next_r.st   = SARPI_QUIET;
               next_r.cnt  = phase_len(QUIET_CYC);
            end
         SARPI_QUIET:
            if (r.cnt == 8'h00)
               next_r.st = SARPI_IDLE;
      endcase
      // A new event wins over a clear in the same cycle
      next_r.status = (r.status & ~clr) | set;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         r          <= '0;
         r.st       <= SARPI_IDLE;
         r.mode     <= CTRL_RESET;
         r.offset   <= OFFSET_RESET;
         r.mask     <= MASK_RESET;
         r.conversion_start_n_n <= 1'b1;
         r.cs_n     <= 1'b1;
         r.rd_n     <= 1'b1;
         r.wr_n     <= 1'b1;
      end
      else
         r <= next_r;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign io.conversion_start_n = r.conversion_start_n_n;
   assign io.cs_n    = r.cs_n;
   assign io.rd_n    = r.rd_n;
   assign io.wr_n    = r.wr_n;
   assign io.mode    = r.mode;
   assign io.host_d  = {3'h0, r.offset};
   assign io.host_oe = r.drive;
   assign o_rdata    = r.rdata;
   assign o_irq      = |(r.status & r.mask);

endmodule

// *** sarpi_if.sv ***
interface sarpi_if;
   import sarpi_pkg::*;

   logic              conversion_start_n;
   logic              busy;
   logic              cs_n;
   logic              rd_n;
   logic              wr_n;
   logic [1:0]        mode;
   logic [DATA_W-1:0] dev_d;
   logic              dev_oe;
   logic [DATA_W-1:0] host_d;
   logic              host_oe;
   logic [DATA_W-1:0] result_bus;

   // ------------------------------------------------------------
   // Resolved bus level; an undriven bus reads as all ones
   // ------------------------------------------------------------
   assign result_bus = dev_oe ? dev_d : (host_oe ? host_d : {DATA_W{1'b1}});

   modport dev  (input conversion_start_n, cs_n, rd_n, wr_n, mode, result_bus,
                 output busy, dev_d, dev_oe);
   modport host (input busy, result_bus,
                 output conversion_start_n, cs_n, rd_n, wr_n, mode, host_d, host_oe);
endinterface

// *** sarpi_monitor.sv ***
module sarpi_monitor
   import sarpi_pkg::*;
(
   // Clock and reset
   input wire logic              i_ref_clk,
   input wire logic              i_arst_n,
   // Link
   input wire logic              conversion_start_n,
   input wire logic              busy,
   input wire logic              cs_n,
   input wire logic              rd_n,
   input wire logic [1:0]        mode,
   input wire logic [DATA_W-1:0] dev_d,
   input wire logic              dev_oe,
   input wire logic              host_oe,
   input wire logic [DATA_W-1:0] result_bus
);
   default clocking mon_cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   property p_mode_legal;
      mode == MODE_IMMEDIATE || mode == MODE_DEFERRED;
   endproperty
   a_mode_legal: assert property (p_mode_legal)
      else $error("mode pins hold a prohibited code");

   property p_imm_load;
      mode == MODE_IMMEDIATE && $changed(dev_d) |-> $rose(busy);
   endproperty
   a_imm_load: assert property (p_imm_load)
      else $error("immediate output register moved off busy rise");

   property p_dfr_load;
      mode == MODE_DEFERRED && $changed(dev_d) |-> $fell(busy);
   endproperty
   a_dfr_load: assert property (p_dfr_load)
      else $error("deferred output register moved off start edge");

   property p_no_read_busy;
      !busy |-> rd_n;
   endproperty
   a_no_read_busy: assert property (p_no_read_busy)
      else $error("read strobe low during conversion");

   property p_oe_gate;
      dev_oe == (!cs_n && !rd_n);
   endproperty
   a_oe_gate: assert property (p_oe_gate)
      else $error("data lines driven without select and read");

   property p_quiet;
      $fell(conversion_start_n) |-> $past(cs_n) && $past(cs_n, 2);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("start edge too soon after bus activity");

   property p_upper_zero;
      host_oe && !dev_oe |-> result_bus[14:12] == 3'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("offset word upper bits not zero");

   property p_offset_range;
      host_oe && !dev_oe |-> $signed(result_bus[11:0]) >= OFFSET_MIN && $signed(result_bus[11:0]) <= OFFSET_MAX;
   endproperty
   a_offset_range: assert property (p_offset_range)
      else $error("offset word out of range");

   property p_busy_drop;
      $fell(conversion_start_n) && busy |=> !busy;
   endproperty
   a_busy_drop: assert property (p_busy_drop)
      else $error("busy did not drop after start edge");

   property p_busy_len;
      $fell(busy) |-> !busy[*6] ##1 busy;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy low time wrong");
endmodule

// *** sarpi_pkg.sv ***
package sarpi_pkg;

   // ------------------------------------------------------------
   // Widths and codes
   // ------------------------------------------------------------
   localparam int          DATA_W         = 15;
   localparam int          OFFS_W         = 12;
   localparam int          OVR_BIT        = 14;
   localparam logic [1:0]  MODE_IMMEDIATE = 2'b01;
   localparam logic [1:0]  MODE_DEFERRED  = 2'b10;
   localparam int          OFFSET_MIN     = -1310;
   localparam int          OFFSET_MAX     = 1310;
   localparam logic [11:0] OFFSET_RESET   = 12'h000;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 20;
   localparam int CONV_TIME_NS   = 300;
   localparam int QUIET_TIME_NS  = 100;
   localparam int RD_PULSE_NS    = 100;
   localparam int WR_PULSE_NS    = 100;
   localparam int CONVERSION_START_N_LOW_NS  = 50;

   // Least times round up, never below one cycle
   function automatic int ns_to_cycles(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int CONV_CYC   = ns_to_cycles(CONV_TIME_NS);
   localparam int QUIET_CYC  = ns_to_cycles(QUIET_TIME_NS);
   localparam int RD_CYC     = ns_to_cycles(RD_PULSE_NS);
   localparam int WR_CYC     = ns_to_cycles(WR_PULSE_NS);
   localparam int CONVERSION_START_N_CYC = ns_to_cycles(CONVERSION_START_N_LOW_NS);

   // ------------------------------------------------------------
   // Controller register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_CMD    = 4'h1;
   localparam logic [3:0] REG_OFFSET = 4'h2;
   localparam logic [3:0] REG_RESULT = 4'h3;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_MASK   = 4'h5;

   localparam int CMD_START_BIT  = 0;
   localparam int CMD_OFFSET_BIT = 1;
   localparam int CMD_ACTIVE_BIT = 2;
   localparam int STAT_DONE_BIT  = 0;
   localparam int STAT_RANGE_BIT = 1;
   localparam int STAT_OVR_BIT   = 2;
   localparam int RES_STALE_BIT  = 15;
   localparam int STAT_W         = 3;

   localparam logic [1:0]        CTRL_RESET = MODE_IMMEDIATE;
   localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;

   typedef enum logic [2:0] {
      SARPI_IDLE,
      SARPI_WRITE,
      SARPI_CONVERSION_START_N,
      SARPI_WAIT_LOW,
      SARPI_WAIT_HIGH,
      SARPI_READ,
      SARPI_QUIET
   } sarpi_state_e;

endpackage

// *** tb.sv ***
module tb
   import sarpi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              i_ref_clk = 1'b0;
   logic              i_arst_n = 1'b0;
   logic [3:0]        i_addr = 4'h0;
   logic [15:0]       i_wdata = 16'h0000;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic [15:0]       o_rdata;
   logic              o_irq;
   logic [DATA_W-1:0] i_sample_code = 15'h0000;
   logic [OFFS_W-1:0] o_offset;
   logic              o_result_invalid;
   int                fail_count = 0;
   int                checks = 0;
   int                off = 0;
   int                exp_q[$];

   sarpi_if link ();
   sarpi_device sarpi_device_inst (.i_ref_clk, .i_arst_n, .io(link), .i_sample_code, .o_offset, .o_result_invalid);
   sarpi_host sarpi_host_inst (.i_ref_clk, .i_arst_n, .io(link), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq);
   sarpi_monitor sarpi_monitor_inst (.i_ref_clk, .i_arst_n, .conversion_start_n(link.conversion_start_n),
      .busy(link.busy), .cs_n(link.cs_n), .rd_n(link.rd_n), .mode(link.mode), .dev_d(link.dev_d),
      .dev_oe(link.dev_oe), .host_oe(link.host_oe), .result_bus(link.result_bus));

   always #25 i_ref_clk = ~i_ref_clk;

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Offset goes out over the link; out-of-range values must leave the old one
   task automatic set_off(input int v);
      int k;
      wr(REG_OFFSET, 16'(v) & 16'h0fff);
      wr(REG_CMD, 16'h0002);
      k = 0;
      do @(posedge i_ref_clk); while (!link.host_oe && ++k < 20);
      chk(16'(link.host_oe), 16'h0001, "offset write started");
      do @(posedge i_ref_clk); while (link.host_oe && ++k < 40);
      chk(16'(link.host_oe), 16'h0000, "offset write ended");
      if (v >= OFFSET_MIN && v <= OFFSET_MAX)
         off = v;
      #1 chk(16'(o_offset), 16'(off) & 16'h0fff, "offset");
   endtask

   // Sample code changes once busy is low, so only the start edge value counts
   task automatic conv(input logic [14:0] code, input bit dfr, input bit first);
      int k;
      logic [15:0] r;
      logic [15:0] e;
      @(posedge i_ref_clk);
      i_sample_code <= code;
      exp_q.push_back(int'(code) + off);
      wr(REG_CMD, 16'h0001);
      k = 0;
      do @(posedge i_ref_clk); while (link.busy && ++k < 20);
      chk(16'(link.busy), 16'h0000, "busy low");
      i_sample_code <= 15'($urandom);
      do @(posedge i_ref_clk); while (!o_irq && ++k < 80);
      chk(16'(o_irq), 16'h0001, "done irq");
      rd(REG_RESULT, r);
      chk(16'(o_result_invalid), 16'(first), "invalid flag");
      if (first)
         chk(r & 16'h8000, 16'h8000, "stale flag");
      else
      begin
         e = {1'b0, 15'(exp_q.pop_front())};
         chk(r, e, "result");
         rd(REG_STATUS, r);
         chk(r, {13'h0, e[14], 2'b01}, "status");
      end
      wr(REG_STATUS, 16'h0007);
      #1 chk({15'h0, o_irq}, 16'h0000, "irq clear");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      int i;
      logic [15:0] r;
      void'($urandom(32'hc05f4dfd));
      repeat (4) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      chk({15'h0, o_result_invalid}, 16'h0001, "invalid flag");
      wr(REG_MASK, 16'h0001);
      wr(REG_CTRL, {14'h0, MODE_DEFERRED});
      for (i = 0; i < 4; i++)
         conv(15'($urandom), 1'b1, i == 0);
      $display("test deferred readout done");
      exp_q.delete();
      wr(REG_CTRL, 16'h0000);
      wr(REG_CTRL, 16'h0003);
      repeat (2) @(posedge i_ref_clk);
      chk({14'h0, link.mode}, {14'h0, MODE_DEFERRED}, "mode");
      rd(REG_CTRL, r);
      chk(r, {14'h0, MODE_DEFERRED}, "ctrl read");
      wr(REG_CTRL, {14'h0, MODE_IMMEDIATE});
      for (i = 0; i < 4; i++)
      begin
         set_off(int'($urandom_range(2620)) - 1310);
         conv(15'($urandom), 1'b0, 1'b0);
      end
      set_off(OFFSET_MAX);
      conv(15'h7fff, 1'b0, 1'b0);
      set_off(OFFSET_MIN);
      conv(15'h0000, 1'b0, 1'b0);
      set_off(1311);
      rd(REG_STATUS, r);
      chk(r & 16'h0002, 16'h0002, "range flag");
      wr(REG_STATUS, 16'h0007);
      conv(15'h1234, 1'b0, 1'b0);
      $display("test offset and immediate readout done");
      rd(4'hf, r);
      chk(r, 16'h0000, "unmapped read");
      wr(REG_MASK, 16'h0000);
      wr(REG_CMD, 16'h0001);
      rd(REG_CMD, r);
      chk(r, 16'h0004, "sequencer active");
      repeat (30) @(posedge i_ref_clk);
      chk({15'h0, o_irq}, 16'h0000, "masked irq");
      rd(REG_STATUS, r);
      chk(r & 16'h0001, 16'h0001, "done flag");
      wr(REG_MASK, 16'h0001);
      #1 chk({15'h0, o_irq}, 16'h0001, "unmasked irq");
      wr(REG_STATUS, 16'h0007);
      #1 chk({15'h0, o_irq}, 16'h0000, "cleared irq");
      $display("test interrupt done");
      end_of_test();
   end

   initial
   begin
      #200us;
      fail_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
